// File: dv/lpcs_far_model.sv
// Purpose: Far side model that brings the lanes into alignment
// Assumes: Alignment follows a fixed delay after the decoder leaves init
// Notes: Alignment is lost on the first clock edge after the decoder restarts
module lpcs_far_model #(
  parameter int unsigned DLY = 6
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Decoder view
  input wire logic tx_local_fault,
  output logic rx_aligned
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 0;
      rx_aligned <= 1'b0;
    end
    else if (tx_local_fault)
    begin
      cnt_q <= 0;
      rx_aligned <= 1'b0;
    end
    else if (cnt_q < DLY)
      cnt_q <= cnt_q + 1;
    else
      rx_aligned <= 1'b1;
  end
endmodule

// File: dv/testbench.sv
// Purpose: Self-checking bench for the link path control block
// Assumes: APB slave answers within 20 cycles
// Notes: Alignment comes from lpcs_far_model
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned N = lpcs_pkg::LANES;
  localparam int unsigned W = lpcs_pkg::ERRW;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic tx_pkt_start, tx_pkt_end, tx_in_packet, tx_local_fault;
  logic rx_pkt_start, rx_pkt_end;
  lpcs_pkg::lpcs_tx_word_t tx_word;
  logic rx_force_realign, rx_aligned, rx_decoding, rx_data_active, irq;
  logic [N*W-1:0] lane_err_raw, rx_framing_err;
  logic [N-1:0] lane_err_hit, rx_framing_err_valid;
  int n_errors = 0;
  int compares = 0;
  lpcs_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_pkt_start(tx_pkt_start), .tx_pkt_end(tx_pkt_end),
    .tx_word(tx_word), .tx_in_packet(tx_in_packet),
    .tx_local_fault(tx_local_fault), .rx_force_realign(rx_force_realign),
    .rx_pkt_start(rx_pkt_start), .rx_pkt_end(rx_pkt_end),
    .rx_aligned(rx_aligned),
    .lane_err_raw(lane_err_raw), .lane_err_hit(lane_err_hit),
    .rx_decoding(rx_decoding), .rx_data_active(rx_data_active),
    .rx_framing_err(rx_framing_err),
    .rx_framing_err_valid(rx_framing_err_valid), .irq(irq));
  lpcs_far_model far_u (.pclk(pclk), .presetn(presetn),
    .tx_local_fault(tx_local_fault), .rx_aligned(rx_aligned));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // Bounded wait: sel 0 watches local fault, 1 watches decoding
  task automatic wt(int sel, logic v, int lim);
    int i;
    for (i = 0; i < lim && (sel == 0 ? tx_local_fault : rx_decoding) !== v;
         i++)
      cyc(1);
    chk("wait", 32'(v), 32'(sel == 0 ? tx_local_fault : rx_decoding));
    if (n_errors != 0)
      end_sim();
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    chk("pready", 32'h1, 32'(pready));
    if (pready !== 1'b1)
      end_sim();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic t_regs();
    apb(1'b0, lpcs_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h8, rd);
    apb(1'b1, 8'h20, 32'hf);
    chk("unmapped err", 32'h1, 32'(er));
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped rd", 32'h0, rd);
    apb(1'b0, lpcs_pkg::OFS_CTRL, 32'h0);
    chk("ctrl kept", 32'h8, rd);
  endtask
  task automatic t_tx();
    logic [31:0] cv [4] = '{32'h9, 32'hb, 32'hd, 32'hf};
    logic [1:0] ew [4] = '{2'b01, 2'b10, 2'b00, 2'b10};
    // Permit only once the receive side is aligned and decoding
    wt(1, 1'b1, 60);
    @(posedge pclk);
    tx_pkt_start <= 1'b1;
    cyc(3);
    chk("word no permit", lpcs_pkg::LPCS_TX_IDLE, tx_word);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, lpcs_pkg::OFS_CTRL, cv[i]);
      cyc(2);
      chk("word mode", 32'(ew[i]), tx_word);
    end
    apb(1'b1, lpcs_pkg::OFS_CTRL, 32'h9);
    @(posedge pclk);
    tx_pkt_start <= 1'b0;
    apb(1'b1, lpcs_pkg::OFS_CTRL, 32'h8);
    cyc(2);
    chk("word mid packet", lpcs_pkg::LPCS_TX_DATA, tx_word);
    @(posedge pclk);
    tx_pkt_start <= 1'b1;
    tx_pkt_end <= 1'b1;
    @(posedge pclk);
    tx_pkt_end <= 1'b0;
    cyc(3);
    chk("word after end", lpcs_pkg::LPCS_TX_IDLE, tx_word);
    chk("no new packet", 32'h0, 32'(tx_in_packet));
    @(posedge pclk);
    tx_pkt_start <= 1'b0;
  endtask
  task automatic t_realign();
    wt(1, 1'b1, 60);
    apb(1'b1, lpcs_pkg::OFS_ISTAT, 32'h7);
    @(posedge pclk);
    rx_force_realign <= 1'b1;
    // One full cycle exceeds the minimum pulse width
    @(posedge pclk);
    rx_force_realign <= 1'b0;
    wt(0, 1'b1, 8);
    cyc(2);
    chk("decode stopped", 32'h0, 32'(rx_decoding));
    wt(0, 1'b0, 40);
    wt(1, 1'b1, 40);
    apb(1'b0, lpcs_pkg::OFS_ISTAT, 32'h0);
    chk("realign event", 32'h1, 32'(rd[lpcs_pkg::E_REALN]));
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, lpcs_pkg::OFS_IMASK, 32'h2);
    chk("irq on", 32'h1, 32'(irq));
    apb(1'b1, lpcs_pkg::OFS_ISTAT, 32'h7);
    chk("irq cleared", 32'h0, 32'(irq));
  endtask
  task automatic lane(int l, logic [3:0] v, logic [N-1:0] ev);
    @(posedge pclk);
    lane_err_hit <= N'(1) << l;
    lane_err_raw <= (N*W)'(v) << (W * l);
    @(posedge pclk);
    lane_err_hit <= '0;
    lane_err_raw <= '1;
    #1;
    chk("lane valid", 32'(ev), 32'(rx_framing_err_valid));
    if (ev != '0)
      chk("lane value", 32'(v), 32'(rx_framing_err[W*l +: W]));
  endtask
  task automatic t_lanes();
    lane(0, 4'hf, N'(1));
    lane(19, 4'h1, N'(1) << 19);
    apb(1'b0, lpcs_pkg::OFS_ERRSUM, 32'h0);
    chk("error sum", 32'h10, rd);
    // Open a receive packet, then drop the permit inside it
    @(posedge pclk);
    rx_pkt_start <= 1'b1;
    @(posedge pclk);
    rx_pkt_start <= 1'b0;
    apb(1'b1, lpcs_pkg::OFS_CTRL, 32'h0);
    cyc(2);
    chk("rx packet open", 32'h1, 32'(rx_data_active));
    chk("decode held", 32'h1, 32'(rx_decoding));
    @(posedge pclk);
    rx_pkt_end <= 1'b1;
    @(posedge pclk);
    rx_pkt_end <= 1'b0;
    wt(1, 1'b0, 20);
    chk("rx packet closed", 32'h0, 32'(rx_data_active));
    lane(3, 4'h5, '0);
    apb(1'b0, lpcs_pkg::OFS_ERRSUM, 32'h0);
    chk("sum silent", 32'h10, rd);
    apb(1'b1, lpcs_pkg::OFS_CTRL, 32'h8);
  endtask
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, tx_pkt_start, tx_pkt_end} = '0;
    {rx_pkt_start, rx_pkt_end} = '0;
    paddr = '0;
    pwdata = '0;
    rx_force_realign = 1'b0;
    lane_err_hit = '0;
    lane_err_raw = '1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_tx();
    t_realign();
    t_lanes();
    end_sim();
  end
endmodule

// File: rtl/lpcs_pkg.sv
// Purpose: Shared constants for the link path control and status block
// Assumes: One clock pclk at 25 MHz, APB register access
// Notes: Byte offsets are word aligned
package lpcs_pkg;
  localparam int unsigned LANES = 20;
  localparam int unsigned ERRW = 4;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned RESYNC_MIN_NS = 5;
  localparam int unsigned RESYNC_MIN_CYC =
    (RESYNC_MIN_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
    (RESYNC_MIN_NS * CLK_MHZ + 999) / 1000;
  // Realign hold in cycles; unused, the decoder leaves init after one cycle
  localparam int unsigned ALIGN_CYC = 16;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_ISTAT = 8'h08;
  localparam logic [7:0] OFS_IMASK = 8'h0c;
  localparam logic [7:0] OFS_ERRSUM = 8'h10;
  // Control bits
  localparam int unsigned B_TXP = 0;
  localparam int unsigned B_FRF = 1;
  localparam int unsigned B_FID = 2;
  localparam int unsigned B_RXP = 3;
  localparam logic [3:0] CTRL_RST = 4'h8;
  // Interrupt events
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned E_LFLT = 0;
  localparam int unsigned E_REALN = 1;
  localparam int unsigned E_FERR = 2;
  // Transmit code words
  typedef enum logic [1:0] {
    LPCS_TX_IDLE = 2'b00,
    LPCS_TX_DATA = 2'b01,
    LPCS_TX_RFLT = 2'b10
  } lpcs_tx_word_t;
  typedef enum logic [1:0] {
    LPCS_DEC_INIT = 2'b00,
    LPCS_DEC_ALIGN = 2'b01,
    LPCS_DEC_RUN = 2'b10
  } lpcs_dec_t;
endpackage

// File: rtl/lpcs_top.sv
// Purpose: Transmit/receive path control and status, APB registers
// Assumes: Resync pin is asynchronous; others on pclk
// Notes: Per-lane error increments come from the lane decoders
// Contract
// - Permit high sends packets; permit low sends only idle words
// - Permit dropped mid-packet: finish packet, start no more
// - Forced remote fault high: send only remote fault words
// - Forced idle high: send only idle words; with forced remote fault also high, remote fault words are sent
// - Local fault flag high exactly while decoder in init
// - Receive permit low: finish packet, stop decode, silence stats
// - Forced realign high resets receive path, then realigns
// - Four-bit sync header error count per lane, twenty lanes
// - Lane error value valid only while its strobe is high
// - Values may change any cycle; each valid one is an increment
//
// The address map and the APB slave port were decided locally.
module lpcs_top #(
  parameter int unsigned LANES = lpcs_pkg::LANES,
  parameter int unsigned ERRW = lpcs_pkg::ERRW
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit path
  input wire logic tx_pkt_start,
  input wire logic tx_pkt_end,
  output lpcs_pkg::lpcs_tx_word_t tx_word,
  output logic tx_in_packet,
  output logic tx_local_fault,
  // Receive path
  input wire logic rx_force_realign,
  input wire logic rx_pkt_start,
  input wire logic rx_pkt_end,
  input wire logic rx_aligned,
  input wire logic [LANES*ERRW-1:0] lane_err_raw,
  input wire logic [LANES-1:0] lane_err_hit,
  output logic rx_decoding,
  output logic rx_data_active,
  output logic [LANES*ERRW-1:0] rx_framing_err,
  output logic [LANES-1:0] rx_framing_err_valid,
  // Interrupt
  output logic irq
);
  logic [3:0] ctrl_q;
  logic [lpcs_pkg::IRQ_W-1:0] istat_q;
  logic [lpcs_pkg::IRQ_W-1:0] imask_q;
  logic [15:0] errsum_q;
  logic wr_en;
  logic rd_en;
  logic tx_permit;
  logic tx_frf;
  logic tx_fid;
  logic rx_permit;

  assign tx_permit = ctrl_q[lpcs_pkg::B_TXP];
  assign tx_frf = ctrl_q[lpcs_pkg::B_FRF];
  assign tx_fid = ctrl_q[lpcs_pkg::B_FID];
  assign rx_permit = ctrl_q[lpcs_pkg::B_RXP];

  // APB: zero wait states, unmapped addresses answer with an error
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= lpcs_pkg::CTRL_RST;
    else if (wr_en && paddr == lpcs_pkg::OFS_CTRL)
      ctrl_q <= pwdata[3:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      imask_q <= '0;
    else if (wr_en && paddr == lpcs_pkg::OFS_IMASK)
      imask_q <= pwdata[lpcs_pkg::IRQ_W-1:0];
  end

  // Realign pin: two-flop synchroniser; only the second flop is read
  logic rsy_m_q;
  logic rsy_s_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rsy_m_q <= 1'b0;
      rsy_s_q <= 1'b0;
    end
    else
    begin
      rsy_m_q <= rx_force_realign;
      rsy_s_q <= rsy_m_q;
    end
  end

  // Transmit: packet tracking; a packet only starts under permit
  logic tx_pkt_q;
  logic tx_may_start;
  assign tx_may_start = tx_permit & ~tx_frf & ~tx_fid;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_pkt_q <= 1'b0;
    else if (tx_pkt_q && tx_pkt_end)
      tx_pkt_q <= 1'b0;
    else if (!tx_pkt_q && tx_pkt_start && tx_may_start)
      tx_pkt_q <= 1'b1;
  end
  assign tx_in_packet = tx_pkt_q;

  // Forced modes override any packet; remote fault wins
  lpcs_pkg::lpcs_tx_word_t tx_word_d;
  always_comb
  begin
    if (tx_frf)
      tx_word_d = lpcs_pkg::LPCS_TX_RFLT;
    else if (tx_fid)
      tx_word_d = lpcs_pkg::LPCS_TX_IDLE;
    else if (tx_pkt_q || (tx_pkt_start && tx_permit))
      tx_word_d = lpcs_pkg::LPCS_TX_DATA;
    else
      tx_word_d = lpcs_pkg::LPCS_TX_IDLE;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_word <= lpcs_pkg::LPCS_TX_IDLE;
    else
      tx_word <= tx_word_d;
  end

  // Receive decoder state; realign forces init
  lpcs_pkg::lpcs_dec_t dec_q;
  logic rx_pkt_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dec_q <= lpcs_pkg::LPCS_DEC_INIT;
    else if (rsy_s_q)
      dec_q <= lpcs_pkg::LPCS_DEC_INIT;
    else
      unique case (dec_q)
        lpcs_pkg::LPCS_DEC_INIT:
          dec_q <= lpcs_pkg::LPCS_DEC_ALIGN;
        lpcs_pkg::LPCS_DEC_ALIGN:
          if (rx_aligned)
            dec_q <= lpcs_pkg::LPCS_DEC_RUN;
        lpcs_pkg::LPCS_DEC_RUN:
          if (!rx_aligned)
            dec_q <= lpcs_pkg::LPCS_DEC_ALIGN;
        default:
          dec_q <= lpcs_pkg::LPCS_DEC_INIT;
      endcase
  end
  assign tx_local_fault = (dec_q == lpcs_pkg::LPCS_DEC_INIT);

  // Receive permit: current packet finishes before decoding stops
  logic rx_run;
  assign rx_run = dec_q == lpcs_pkg::LPCS_DEC_RUN;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_pkt_q <= 1'b0;
    else if (!rx_run || (rx_pkt_q && rx_pkt_end))
      rx_pkt_q <= 1'b0;
    else if (!rx_pkt_q && rx_pkt_start && rx_permit)
      rx_pkt_q <= 1'b1;
  end
  logic rx_dec_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_dec_q <= 1'b0;
    else
      rx_dec_q <= rx_run & (rx_permit | rx_pkt_q);
  end
  assign rx_decoding = rx_dec_q;
  assign rx_data_active = rx_pkt_q;

  // Per-lane framing error increments
  logic [LANES-1:0] fe_any;
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          rx_framing_err[g*ERRW +: ERRW] <= '0;
          rx_framing_err_valid[g] <= 1'b0;
        end
        else
        begin
          rx_framing_err[g*ERRW +: ERRW] <=
            lane_err_raw[g*ERRW +: ERRW];
          rx_framing_err_valid[g] <= lane_err_hit[g] & rx_dec_q;
        end
      end
      assign fe_any[g] = rx_framing_err_valid[g] &
        (rx_framing_err[g*ERRW +: ERRW] != '0);

      property p_valid_tracks;
        @(posedge pclk) disable iff (!presetn)
          rx_framing_err_valid[g] |->
            $past(lane_err_hit[g]) && $past(rx_dec_q);
      endproperty
      a_valid_tracks: assert property (p_valid_tracks)
        else $error("lane valid without decode");
      // The increment must be the one the lane decoder offered
      property p_value_tracks;
        @(posedge pclk) disable iff (!presetn)
          rx_framing_err_valid[g] |->
            rx_framing_err[g*ERRW +: ERRW] ==
            $past(lane_err_raw[g*ERRW +: ERRW]);
      endproperty
      a_value_tracks: assert property (p_value_tracks)
        else $error("lane increment not passed on");
    end
  endgenerate

  // Summary counter of reported increments
  logic [15:0] inc_sum;
  always_comb
  begin
    inc_sum = '0;
    for (int i = 0; i < LANES; i++)
      if (rx_framing_err_valid[i])
        inc_sum = inc_sum + 16'(rx_framing_err[i*ERRW +: ERRW]);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      errsum_q <= '0;
    else
      errsum_q <= errsum_q + inc_sum;
  end

  // Sticky events; set wins over write-one-clear
  logic [lpcs_pkg::IRQ_W-1:0] ev;
  logic [lpcs_pkg::IRQ_W-1:0] w1c;
  assign ev[lpcs_pkg::E_LFLT] = tx_local_fault;
  assign ev[lpcs_pkg::E_REALN] = rsy_s_q;
  assign ev[lpcs_pkg::E_FERR] = |fe_any;
  assign w1c = (wr_en && paddr == lpcs_pkg::OFS_ISTAT) ?
    pwdata[lpcs_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      istat_q <= '0;
    else
      istat_q <= (istat_q & ~w1c) | ev;
  end
  assign irq = |(istat_q & imask_q);

  // Read mux
  logic [31:0] rdata_d;
  logic hit;
  always_comb
  begin
    rdata_d = '0;
    hit = 1'b1;
    unique case (paddr)
      lpcs_pkg::OFS_CTRL: rdata_d[3:0] = ctrl_q;
      lpcs_pkg::OFS_STAT: rdata_d[5:0] = {rx_pkt_q, rx_dec_q, dec_q,
        tx_pkt_q, tx_local_fault};
      lpcs_pkg::OFS_ISTAT: rdata_d[lpcs_pkg::IRQ_W-1:0] = istat_q;
      lpcs_pkg::OFS_IMASK: rdata_d[lpcs_pkg::IRQ_W-1:0] = imask_q;
      lpcs_pkg::OFS_ERRSUM: rdata_d[15:0] = errsum_q;
      default: hit = 1'b0;
    endcase
  end
  assign prdata = rd_en ? rdata_d : '0;
  assign pslverr = psel & penable & ~hit;

  property p_rf_prio;
    @(posedge pclk) disable iff (!presetn)
      tx_frf |=> tx_word == lpcs_pkg::LPCS_TX_RFLT;
  endproperty
  a_rf_prio: assert property (p_rf_prio)
    else $error("remote fault not sent");
  property p_idle;
    @(posedge pclk) disable iff (!presetn)
      tx_fid && !tx_frf |=> tx_word == lpcs_pkg::LPCS_TX_IDLE;
  endproperty
  a_idle: assert property (p_idle)
    else $error("forced idle not sent");
  property p_both;
    @(posedge pclk) disable iff (!presetn)
      tx_frf && tx_fid |=> tx_word != lpcs_pkg::LPCS_TX_IDLE;
  endproperty
  a_both: assert property (p_both)
    else $error("idle won over remote fault");
  property p_noperm;
    @(posedge pclk) disable iff (!presetn)
      !tx_permit && !tx_pkt_q |=> !tx_pkt_q;
  endproperty
  a_noperm: assert property (p_noperm)
    else $error("packet began without permit");
  property p_finish;
    @(posedge pclk) disable iff (!presetn)
      tx_pkt_q && !tx_pkt_end |=> tx_pkt_q;
  endproperty
  a_finish: assert property (p_finish)
    else $error("packet cut short");
  // Init lasts one cycle unless the realign request is still held
  property p_lf;
    @(posedge pclk) disable iff (!presetn)
      tx_local_fault && !rsy_s_q |=> !tx_local_fault;
  endproperty
  a_lf: assert property (p_lf)
    else $error("local fault mismatch");
  property p_realign;
    @(posedge pclk) disable iff (!presetn)
      rsy_s_q |=> tx_local_fault && dec_q == lpcs_pkg::LPCS_DEC_INIT;
  endproperty
  a_realign: assert property (p_realign)
    else $error("realign did not reset decoder");
  property p_rxoff;
    @(posedge pclk) disable iff (!presetn)
      !rx_permit && !rx_pkt_q |=>
        !rx_dec_q ##1 rx_framing_err_valid == '0;
  endproperty
  a_rxoff: assert property (p_rxoff)
    else $error("decode kept after permit drop");
endmodule
